// file: verilog/flbr_readout.sv
// fault log ring capture and 255-byte record readout over apb
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "flbr_defines.svh"

module flbr_readout (
  // clock, reset, enable
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                ce,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // telemetry and capture
  input  wire logic                conv_done,
  input  wire flbr_pkg::flbr_tele_t tele_i,
  input  wire flbr_pkg::flbr_peak_t peak_i,
  input  wire logic [40:0]         shared_time_i,
  input  wire logic                fault_lock,
  // status
  output logic                     conv_busy,
  output logic                     log_locked
);

  flbr_pkg::flbr_state_t q;
  flbr_pkg::flbr_state_t n;
  logic                  wr_en;
  logic                  dat_rd;
  logic                  decoded;

  // one telemetry byte by loop position
  function automatic logic [7:0] loop_byte(input flbr_pkg::flbr_tele_t t,
                                           input logic [5:0] pos);
    logic [5:0] d;
    logic [2:0] base;
    logic [1:0] kind;
    logic [2:0] ch;
    logic [2:0] sub;
    logic [15:0] w;
    d = pos;
    base = 3'h0;
    kind = 2'h0;
    if (pos < `FLBR_POS_VIN) begin
      d = pos;
    end else if (pos < `FLBR_POS_CH2) begin
      kind = 2'h1;
      d = pos - `FLBR_POS_VIN;
    end else if (pos < `FLBR_POS_TEMP) begin
      base = 3'h2;
      d = pos - `FLBR_POS_CH2;
    end else if (pos < `FLBR_POS_CH4) begin
      kind = 2'h2;
      d = pos - `FLBR_POS_TEMP;
    end else begin
      base = 3'h4;
      d = pos - `FLBR_POS_CH4;
    end
    ch = 3'(base + 3'(d / `FLBR_CH_GRP));
    sub = 3'(d % `FLBR_CH_GRP);
    w = (kind == 2'h1) ? t.vin : t.temp;
    if (kind == 2'h0) begin
      unique case (sub)
        3'h0:    loop_byte = t.vout[ch][7:0];
        3'h1:    loop_byte = t.vout[ch][15:8];
        3'h2:    loop_byte = t.vout_stat[ch];
        3'h3:    loop_byte = t.mfr_stat[ch];
        default: loop_byte = t.extra_stat[ch][7:0];
      endcase
    end else if (d == 6'h0) begin
      loop_byte = w[7:0];
    end else if (d == 6'h1) begin
      loop_byte = w[15:8];
    end else begin
      loop_byte = (kind == 2'h1) ? t.vin_stat : t.temp_stat;
    end
  endfunction : loop_byte

  // one byte of the returned record by index
  function automatic logic [7:0] rec_byte(input flbr_pkg::flbr_state_t s,
                                          input flbr_pkg::flbr_tele_t t,
                                          input flbr_pkg::flbr_peak_t p,
                                          input logic [7:0] i);
    logic [7:0]  off;
    logic [7:0]  a;
    logic [7:0]  d;
    logic [7:0]  g;
    logic [2:0]  ch;
    logic [15:0] w;
    logic [47:0] tw;
    rec_byte = 8'h00;
    off = i - `FLBR_PRE_LEN;
    // ring slot walks backwards from the newest byte, wrapping
    a = (s.last_idx >= off) ? s.last_idx - off : s.last_idx + `FLBR_RING_LEN - off;
    tw = {7'h00, s.time_cap};
    d = 8'h00;
    g = 8'h00;
    if (i == `FLBR_PTR_BYTE) begin
      rec_byte = {2'h0, s.last_pos};
    end else if (i == `FLBR_VCNT_BYTE) begin
      rec_byte = (s.valid_cnt >= `FLBR_RING_LEN) ? `FLBR_CNT_ALL : s.valid_cnt;
    end else if (i < `FLBR_PEAK_BASE) begin
      d = i - `FLBR_TIME_BASE;
      rec_byte = tw[{d[2:0], 3'h0} +: 8];
    end else if (i < `FLBR_STAT_BASE) begin
      d = i - `FLBR_PEAK_BASE;
      g = {2'h0, d[7:2]};
      if (g == `FLBR_GRP_VIN) begin
        w = d[1] ? p.vin_min : p.vin_peak;
      end else if (g == `FLBR_GRP_TEMP) begin
        w = d[1] ? p.temp_min : p.temp_peak;
      end else begin
        ch = (g < `FLBR_GRP_VIN) ? g[2:0] :
             (g < `FLBR_GRP_TEMP) ? 3'(g - 8'h1) : 3'(g - 8'h2);
        w = d[1] ? p.vout_min[ch] : p.vout_peak[ch];
      end
      rec_byte = d[0] ? w[15:8] : w[7:0];
    end else if (i < `FLBR_PRE_LEN) begin
      d = i - `FLBR_STAT_BASE;
      ch = 3'(d / `FLBR_STAT_GRP);
      unique case (8'(d % `FLBR_STAT_GRP))
        8'h0:    rec_byte = t.vout_stat[ch];
        8'h1:    rec_byte = t.mfr_stat[ch];
        default: rec_byte = t.extra_stat[ch][7:0];
      endcase
    end else if (i <= `FLBR_CYC_LAST) begin
      rec_byte = s.ring[a];
    end else begin
      rec_byte = 8'h00;
    end
  endfunction : rec_byte

  // bus decode and handshake; ce low stretches the access
  assign decoded = (paddr == `FLBR_ADDR_CTRL) || (paddr == `FLBR_ADDR_STAT) ||
                   (paddr == `FLBR_ADDR_INDEX) || (paddr == `FLBR_ADDR_DATA) ||
                   (paddr == `FLBR_ADDR_COUNT);
  assign pready = ce;
  assign pslverr = psel & penable & ~decoded;
  assign prdata = q.prdata;
  assign dat_rd = psel & penable & ~pwrite & (paddr == `FLBR_ADDR_DATA);
  // a locked log never takes telemetry
  assign wr_en = q.busy & ~q.lock & ce;
  assign conv_busy = q.busy;
  assign log_locked = q.lock;

  // next state
  always_comb begin
    n = q;
    if (ce) begin
      // read data latched in setup so prdata comes from a flop
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `FLBR_ADDR_CTRL:  n.prdata = {31'h0, q.lock};
          `FLBR_ADDR_STAT:  n.prdata = {15'h0, q.busy,
                                        rec_byte(q, tele_i, peak_i, `FLBR_VCNT_BYTE),
                                        2'h0, q.last_pos};
          `FLBR_ADDR_INDEX: n.prdata = {24'h0, q.rd_idx};
          `FLBR_ADDR_DATA:  n.prdata = {24'h0, rec_byte(q, tele_i, peak_i, q.rd_idx)};
          `FLBR_ADDR_COUNT: n.prdata = `FLBR_BYTE_COUNT;
          default:          n.prdata = 32'h0;
        endcase
      end
      // register writes; record itself is read-only
      if (psel && penable && pwrite) begin
        if (paddr == `FLBR_ADDR_CTRL) begin
          n.lock = pwdata[`FLBR_CTRL_LOCK];
          if (pwdata[`FLBR_CTRL_CLR]) begin
            n.valid_cnt = 8'h0;
          end
        end
        if (paddr == `FLBR_ADDR_INDEX) begin
          n.rd_idx = pwdata[7:0];
        end
      end
      // streaming reads walk the record byte by byte
      if (dat_rd && q.rd_idx != `FLBR_IDX_MAX) begin
        n.rd_idx = q.rd_idx + 8'h1;
      end
      // fault set wins over a software release in the same cycle
      if (fault_lock) begin
        n.lock = 1'b1;
      end
      if (n.lock && !q.lock) begin
        n.time_cap = shared_time_i;
      end
      // start a loop after each conversion that arrives while idle and unlocked
      if (conv_done && !q.busy && !q.lock) begin
        n.busy = 1'b1;
        n.seq_cnt = 6'h0;
      end
      if (q.lock) begin
        n.busy = 1'b0;
      end
      if (wr_en) begin
        n.ring[q.wr_idx] = loop_byte(tele_i, q.pos);
        n.last_idx = q.wr_idx;
        n.last_pos = q.pos;
        n.wr_idx = (q.wr_idx == `FLBR_RING_MAX) ? 8'h0 : q.wr_idx + 8'h1;
        n.pos = (q.pos == `FLBR_LOOP_LAST) ? 6'h0 : q.pos + 6'h1;
        if (n.valid_cnt < `FLBR_RING_LEN) begin
          n.valid_cnt = n.valid_cnt + 8'h1;
        end
        n.seq_cnt = q.seq_cnt + 6'h1;
        if (q.seq_cnt == `FLBR_LOOP_LAST) begin
          n.busy = 1'b0;
        end
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // checks on the record and the capture logic
  a_count_value: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && paddr == `FLBR_ADDR_COUNT && ce && $past(ce)
    |-> prdata == `FLBR_BYTE_COUNT)
    else $error("block count register not 0xFF");
  a_ptr_byte: assert property (@(posedge pclk) disable iff (!presetn)
    dat_rd && ce && $past(ce) && $past(q.lock) && q.rd_idx == `FLBR_PTR_BYTE
    |-> prdata == {26'h0, q.last_pos})
    else $error("record byte 0 not the saved pointer");
  a_valid_full: assert property (@(posedge pclk) disable iff (!presetn)
    // count as it stood in the setup cycle, when the byte was loaded
    dat_rd && ce && $past(ce) && q.rd_idx == `FLBR_VCNT_BYTE
    && $past(q.valid_cnt) >= `FLBR_RING_LEN
    |-> prdata[7:0] == `FLBR_CNT_ALL)
    else $error("full ring not reported as 0xFF");
  a_extra_low: assert property (@(posedge pclk) disable iff (!presetn)
    dat_rd && ce && $past(ce) && q.rd_idx == `FLBR_EXTRA0_BYTE
    |-> prdata == {24'h0, $past(tele_i.extra_stat[0][7:0])})
    else $error("byte 50 not channel 0 extra status low");
  a_cyc_start: assert property (@(posedge pclk) disable iff (!presetn)
    dat_rd && ce && $past(ce) && $past(q.lock) && q.rd_idx == `FLBR_PRE_LEN
    |-> prdata[7:0] == q.ring[q.last_idx])
    else $error("byte 72 not the newest loop entry");
  a_cyc_reverse: assert property (@(posedge pclk) disable iff (!presetn)
    dat_rd && ce && $past(ce) && $past(q.lock) && q.rd_idx == `FLBR_CYC_SECOND
    |-> prdata[7:0] == q.ring[(q.last_idx == 8'h0) ? `FLBR_RING_MAX : q.last_idx - 8'h1])
    else $error("byte 73 not the previous loop entry");
  a_tail_zero: assert property (@(posedge pclk) disable iff (!presetn)
    dat_rd && ce && $past(ce) && q.rd_idx > `FLBR_CYC_LAST |-> prdata == 32'h0)
    else $error("reserved record byte not zero");
  a_pos_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && q.pos == `FLBR_LOOP_LAST |=> q.pos == 6'h0 && q.last_pos == `FLBR_LOOP_LAST)
    else $error("loop position did not wrap after 45");
  a_vin_high: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && q.pos == `FLBR_POS_VIN_HI |=> q.ring[$past(q.wr_idx)] == $past(tele_i.vin[15:8]))
    else $error("position 11 not input voltage high byte");
  a_lock_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    // with ce low nothing moves, so the abort lands on the next enabled edge
    q.lock && ce |=> q.wr_idx == $past(q.wr_idx) && !q.busy)
    else $error("ring written while locked");

endmodule : flbr_readout

// file: verilog/flbr_defines.svh
// constants for the fault log block readout
`ifndef FLBR_DEFINES_SVH
`define FLBR_DEFINES_SVH

// record layout
`define FLBR_NCH         8
`define FLBR_PTR_BYTE    8'h00
`define FLBR_VCNT_BYTE   8'h01
`define FLBR_TIME_BASE   8'h02
`define FLBR_PEAK_BASE   8'h08
`define FLBR_STAT_BASE   8'h30
`define FLBR_STAT_GRP    8'h03
`define FLBR_EXTRA0_BYTE 8'h32
`define FLBR_PRE_LEN     8'h48
`define FLBR_CYC_SECOND  8'h49
`define FLBR_CYC_LAST    8'hED
`define FLBR_REC_LAST    8'hFE
`define FLBR_IDX_MAX     8'hFF
`define FLBR_RING_LEN    8'hA6
`define FLBR_RING_MAX    8'hA5
`define FLBR_CNT_ALL     8'hFF
`define FLBR_BYTE_COUNT  32'h000000FF
`define FLBR_GRP_VIN     8'h02
`define FLBR_GRP_TEMP    8'h05

// telemetry loop layout
`define FLBR_LOOP_LAST   6'h2D
`define FLBR_POS_VIN     6'h0A
`define FLBR_POS_VIN_HI  6'h0B
`define FLBR_POS_CH2     6'h0D
`define FLBR_POS_TEMP    6'h17
`define FLBR_POS_CH4     6'h1A
`define FLBR_CH_GRP      6'h05

// register map and fields
`define FLBR_ADDR_CTRL  12'h000
`define FLBR_ADDR_STAT  12'h004
`define FLBR_ADDR_INDEX 12'h008
`define FLBR_ADDR_DATA  12'h00C
`define FLBR_ADDR_COUNT 12'h010
`define FLBR_CTRL_LOCK  0
`define FLBR_CTRL_CLR   1

`endif

// file: verilog/flbr_pkg.sv
// types for the fault log block readout
`include "flbr_defines.svh"

package flbr_pkg;

  // live telemetry of one conversion cycle
  typedef struct packed {
    logic [`FLBR_NCH-1:0][15:0] vout;
    logic [`FLBR_NCH-1:0][7:0]  vout_stat;
    logic [`FLBR_NCH-1:0][7:0]  mfr_stat;
    logic [`FLBR_NCH-1:0][15:0] extra_stat;
    logic [15:0]                vin;
    logic [7:0]                 vin_stat;
    logic [15:0]                temp;
    logic [7:0]                 temp_stat;
  } flbr_tele_t;

  // peak and minimum values
  typedef struct packed {
    logic [`FLBR_NCH-1:0][15:0] vout_peak;
    logic [`FLBR_NCH-1:0][15:0] vout_min;
    logic [15:0]                vin_peak;
    logic [15:0]                vin_min;
    logic [15:0]                temp_peak;
    logic [15:0]                temp_min;
  } flbr_peak_t;

  // all state of the readout block
  typedef struct packed {
    logic [`FLBR_RING_LEN-1:0][7:0] ring;
    logic [7:0]                     wr_idx;
    logic [7:0]                     last_idx;
    logic [5:0]                     pos;
    logic [5:0]                     last_pos;
    logic [5:0]                     seq_cnt;
    logic                           busy;
    logic                           lock;
    logic [7:0]                     valid_cnt;
    logic [40:0]                    time_cap;
    logic [7:0]                     rd_idx;
    logic [31:0]                    prdata;
  } flbr_state_t;

endpackage : flbr_pkg

// file: tb/flbr_host_model.sv
// host side decode of a record byte number into a loop position
`timescale 1ns/100ps

module flbr_host_model (
  // saved pointer and record byte number
  input  wire logic [5:0] ptr,
  input  wire logic [7:0] idx,
  // loop position that this byte came from
  output logic      [5:0] pos
);
  int d;

  // byte 72 is the pointer entry, later bytes step down, below zero wraps to 45
  always_comb begin
    d = (int'(ptr) - (int'(idx) - 72)) % 46;
    if (d < 0) d = d + 46;
    pos = 6'(d);
  end
endmodule : flbr_host_model

// file: tb/flbr_readout_tb.sv
// self-checking bench for the fault log record readout
`timescale 1ns/100ps

module flbr_readout_tb;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, conv_done = 0, fault_lock = 0, conv_busy, log_locked, err;
  logic [40:0] tm = 41'h0;
  logic [447:0] rb;
  logic [5:0] p, pos_w;
  logic [7:0] idx_v = 8'h00;
  flbr_pkg::flbr_tele_t tele_i, ta, tb, tc;
  flbr_pkg::flbr_peak_t peak_i;
  int error_cnt = 0, checks_done = 0, cyc = 0, seed = 32'hfcc3;

  flbr_readout i_flbr_readout (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_done(conv_done), .tele_i(tele_i),
    .peak_i(peak_i), .shared_time_i(tm), .fault_lock(fault_lock), .conv_busy(conv_busy),
    .log_locked(log_locked));
  flbr_host_model i_flbr_host_model (.ptr(p), .idx(idx_v), .pos(pos_w));

  always #5 pclk = ~pclk;
  // hang guard, a full readout needs well under this
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      error_cnt++;
    end
  endtask : chk

  // one apb transfer, held until pready at a rising edge
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  task automatic rnd();
    for (int i = 0; i < 14; i++) rb[i*32+:32] = $random(seed);
  endtask : rnd

  // one conversion loop, waits for the write to finish
  task automatic conv(flbr_pkg::flbr_tele_t t, int lock_at);
    @(posedge pclk);
    tele_i <= t; conv_done <= 1;
    @(posedge pclk);
    conv_done <= 0;
    if (lock_at > 0) begin
      repeat (lock_at) @(posedge pclk);
      fault_lock <= 1;
      @(posedge pclk);
      fault_lock <= 0;
    end
    do begin @(posedge pclk); #1; end while (conv_busy !== 1'b0);
  endtask : conv

  // expected loop byte at a position
  function automatic logic [7:0] lb(flbr_pkg::flbr_tele_t t, int q);
    int c, o;
    if (q >= 10 && q < 13) return (q == 10) ? t.vin[7:0] : (q == 11) ? t.vin[15:8] : t.vin_stat;
    if (q >= 23 && q < 26) return (q == 23) ? t.temp[7:0] : (q == 24) ? t.temp[15:8] : t.temp_stat;
    c = (q < 10) ? q / 5 : (q < 23) ? 2 + (q - 13) / 5 : 4 + (q - 26) / 5;
    o = (q < 10) ? q % 5 : (q < 23) ? (q - 13) % 5 : (q - 26) % 5;
    case (o)
      0: return t.vout[c][7:0];
      1: return t.vout[c][15:8];
      2: return t.vout_stat[c];
      3: return t.mfr_stat[c];
      default: return t.extra_stat[c][7:0];
    endcase
  endfunction : lb

  // expected record byte, newest loop first in the cyclic part
  function automatic logic [7:0] er(int i);
    int g, o, c, k;
    logic [15:0] v;
    if (i == 0) return 8'(p);
    if (i == 1) return 8'hFF;
    if (i < 8) return 8'(tm >> (8 * (i - 2)));
    if (i < 48) begin
      g = (i - 8) / 4; o = (i - 8) % 4; c = (g < 2) ? g : (g < 5) ? g - 1 : g - 2;
      v = (g == 2) ? ((o < 2) ? peak_i.vin_peak : peak_i.vin_min) :
          (g == 5) ? ((o < 2) ? peak_i.temp_peak : peak_i.temp_min) :
          ((o < 2) ? peak_i.vout_peak[c] : peak_i.vout_min[c]);
      return o[0] ? v[15:8] : v[7:0];
    end
    if (i < 72) begin
      c = (i - 48) / 3; o = (i - 48) % 3;
      return (o == 0) ? tc.vout_stat[c] : (o == 1) ? tc.mfr_stat[c] : tc.extra_stat[c][7:0];
    end
    k = i - 72;
    if (i > 237) return 8'h00;
    return (k <= p) ? lb(tc, pos_w) : (k <= p + 46) ? lb(tb, pos_w) : lb(ta, pos_w);
  endfunction : er

  initial begin
    rnd();
    tele_i <= flbr_pkg::flbr_tele_t'(rb[431:0]);
    peak_i <= flbr_pkg::flbr_peak_t'(rb[319:0]);
    // the fault is injected so that position 11 is the last one written
    p = 6'h0B;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    rnd(); ta = flbr_pkg::flbr_tele_t'(rb[431:0]);
    rnd(); tb = flbr_pkg::flbr_tele_t'(rb[431:0]);
    rnd(); tc = flbr_pkg::flbr_tele_t'(rb[431:0]); peak_i <= flbr_pkg::flbr_peak_t'(rb[319:0]);
    tm <= 41'(rb[447:384]) | 41'h100_0000_0000;
    conv(ta, 0);
    // one loop in: pointer 45 and 46 valid bytes
    apb(0, 12'h004, 32'h0);
    chk("status_part", 32'h0000_2E2D, r);
    // three more full loops fill all 166 ring bytes before the fault
    conv(ta, 0);
    conv(ta, 0);
    conv(tb, 0);
    // abort the last loop after position 11
    conv(tc, 11);
    chk("locked", 32'h1, 32'(log_locked));
    // no loop may start while locked
    @(posedge pclk);
    conv_done <= 1;
    @(posedge pclk);
    conv_done <= 0;
    repeat (2) @(posedge pclk);
    chk("busy_locked", 32'h0, 32'(conv_busy));
    apb(0, 12'h004, 32'h0);
    chk("status", {16'h0000, 8'hFF, 2'h0, p}, r);
    apb(0, 12'h010, 32'h0);
    chk("count", 32'h0000_00FF, r);
    apb(0, 12'h014, 32'h0);
    chk("unmapped_err", 32'h1, 32'(err));
    chk("unmapped_rd", 32'h0, r);
    apb(1, 12'h00C, 32'h0000_00A5);
    apb(1, 12'h008, 32'h0);
    // bus data byte 0 is record byte 0, read up to the saturating end
    for (int i = 0; i < 256; i++) begin
      idx_v = 8'(i);
      apb(0, 12'h00C, 32'h0);
      chk($sformatf("rec%0d", i), 32'(er(i)), r);
    end
    apb(0, 12'h008, 32'h0);
    chk("index_sat", 32'h0000_00FF, r);
    // replay from byte 72: vin high, vin low, channel 1 extra status low
    apb(1, 12'h008, 32'h0000_0048);
    apb(0, 12'h00C, 32'h0);
    chk("vin_hi", 32'(tc.vin[15:8]), r);
    // ce low in the access phase stretches the read; the index steps once
    fork
      apb(0, 12'h00C, 32'h0);
      begin
        repeat (2) @(posedge pclk);
        ce <= 0;
        repeat (2) @(posedge pclk);
        ce <= 1;
      end
    join
    chk("vin_lo", 32'(tc.vin[7:0]), r);
    apb(0, 12'h00C, 32'h0);
    chk("ch1_extra", 32'(tc.extra_stat[1][7:0]), r);
    report_and_stop();
  end
endmodule : flbr_readout_tb
